// file: logic/ids_avs_slave.sv
/*
  Avalon-MM slave front end with waitrequest: every access answers after one wait cycle.
  Assumes the master holds its request until it samples waitrequest low.
*/
`timescale 1ns/100ps
module ids_avs_slave import ids_pkg::*; (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire ids_av_req_t           req_i,
  input  wire logic [IDS_REG_W-1:0]  rdata_i,
  output ids_reg_acc_t               acc_o,
  output logic [IDS_DATA_W-1:0]      readdata_q,
  output logic                       waitrequest_q
);

  ids_hs_state_t state_q;
  logic          req_on;

  assign req_on = req_i.read | req_i.write;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= IDS_HS_IDLE;
    end else begin
      case (state_q)
        IDS_HS_IDLE: begin
          if (req_on) begin
            state_q <= IDS_HS_ACK;
          end
        end
        IDS_HS_ACK: state_q <= IDS_HS_IDLE;
        default:    state_q <= IDS_HS_IDLE;
      endcase
    end
  end

  // Waitrequest is high at rest so that no request ever completes unseen.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      waitrequest_q <= 1'b1;
    end else begin
      waitrequest_q <= !(state_q == IDS_HS_IDLE && req_on);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      readdata_q <= '0;
    end else if (state_q == IDS_HS_IDLE && req_i.read) begin
      readdata_q <= {{(IDS_DATA_W-IDS_REG_W){1'b0}}, rdata_i};
    end
  end

  // The write lands at the edge where the master sees waitrequest low.
  always_comb begin
    acc_o.wr    = req_i.write && (state_q == IDS_HS_ACK);
    acc_o.idx   = req_i.addr[IDS_ADDR_W-1:2];
    acc_o.wdata = req_i.wdata[IDS_REG_W-1:0];
    acc_o.be    = req_i.be[1:0];
  end

endmodule : ids_avs_slave

// file: logic/ids_idle_ctrl.sv
/*
  Idle domain control and status: sleep control, per-unit select, domain status flags,
  clock-generator sequencing check and an event interrupt, behind an Avalon-MM slave.
  Assumes idle_exec and wake_req are single-cycle pulses from logic on ref_clk.
*/
// Operation
// - Master domain control bit idles DMA and host port.
// - Core control bit 0 idles the core.
// - Status bit 8 shows fetch bus asleep.
// - Status bit 7 shows master bus asleep.
// - Status bit 6 shows I/O space bus asleep.
// - Status bit 5 shows external memory asleep.
// - Status bit 4 shows clock generator stopped.
// - Status bit 3 shows peripheral domain asleep.
// - Status bit 2 shows instruction cache asleep.
// - Status bit 1 shows DMA and host port asleep.
// - Status bit 0 shows core asleep.
// - Status read-only, bits 15..9 zero, resets zero.
// - Peripheral idle sleeps only selected units.
// - Clock idle without other bits raises bus error.
// - Idle wakes sleeping units whose select is zero.
// - Peripheral bit zero: idle wakes every unit.
`timescale 1ns/100ps
module ids_idle_ctrl import ids_pkg::*; (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire logic [IDS_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [IDS_DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [IDS_DATA_W-1:0] avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  idle_exec,
  input  wire logic                  wake_req,
  output logic                       core_sleep,
  output logic                       master_domain_sleep,
  output logic                       instr_cache_sleep,
  output logic                       units_sleep,
  output logic                       clock_gen_sleep,
  output logic                       ext_memory_sleep,
  output logic                       io_space_bus_sleep,
  output logic                       master_bus_sleep,
  output logic                       fetch_bus_sleep,
  output logic      [IDS_UNIT_N-1:0] unit_sleep_vec,
  output logic                       bus_error_irq,
  output logic                       irq
);

  ids_av_req_t          av_req;
  ids_reg_acc_t         acc;
  logic [IDS_REG_W-1:0] rdata;
  logic [IDS_REG_W-1:0] cfg_q;
  logic [IDS_REG_W-1:0] select_q;
  logic [IDS_DOM_N-1:0] status_flags;
  logic [IDS_DOM_N-1:0] status_d;
  logic [IDS_UNIT_N-1:0] unit_flags;
  logic [IDS_UNIT_N-1:0] unit_d;
  logic [IDS_EV_N-1:0]  evt_stat_q;
  logic [IDS_EV_N-1:0]  evt_en_q;
  logic [IDS_EV_N-1:0]  evt_set;
  logic [IDS_EV_N-1:0]  evt_clr;
  logic [IDS_EV_N-1:0]  evt_stat_d;
  logic                 clk_seq_bad;
  logic                 enter;
  logic                 wake;
  logic                 load;
  logic                 any_asleep;

  always_comb begin
    av_req.read  = avs_read;
    av_req.write = avs_write;
    av_req.addr  = avs_address;
    av_req.wdata = avs_writedata;
    av_req.be    = avs_byteenable;
  end

  ids_avs_slave u_slave (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .req_i         (av_req),
    .rdata_i       (rdata),
    .acc_o         (acc),
    .readdata_q    (avs_readdata),
    .waitrequest_q (avs_waitrequest)
  );

  function automatic logic [IDS_REG_W-1:0] be_merge(
    input logic [IDS_REG_W-1:0] old_v,
    input logic [IDS_REG_W-1:0] new_v,
    input logic [1:0]           be
  );
    logic [IDS_REG_W-1:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction : be_merge

  // Sleep control register; bit 9 arms the clock generator stop.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= IDS_CFG_RST;
    end else if (acc.wr && acc.idx == IDS_IDX_CFG) begin
      cfg_q <= be_merge(cfg_q, acc.wdata, acc.be) & IDS_CFG_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      select_q <= IDS_SELECT_RST;
    end else if (acc.wr && acc.idx == IDS_IDX_SELECT) begin
      select_q <= be_merge(select_q, acc.wdata, acc.be) & IDS_SELECT_MASK;
    end
  end

  // Stopping the clock with any domain other than the peripheral domain still awake would leave
  // that domain without a clock and unable to quiesce, so the idle is refused as a bus error.
  always_comb begin
    clk_seq_bad = cfg_q[IDS_B_CLKGEN] &&
                  (((cfg_q & IDS_CLK_REQ_MASK) != IDS_CLK_REQ_MASK) ||
                   !cfg_q[IDS_B_CLKEN]);
    enter       = idle_exec && !clk_seq_bad;
    any_asleep  = (status_flags != '0) || (unit_flags != '0);
    wake        = wake_req && !enter;
    load        = enter || wake;
  end

  // On idle every domain takes its control bit; a wake returns all to active.
  always_comb begin
    status_d = IDS_STATUS_RST;
    unit_d   = '0;
    if (enter) begin
      status_d[IDS_B_CORE]   = cfg_q[IDS_B_CORE];
      status_d[IDS_B_MASTER] = cfg_q[IDS_B_MASTER];
      status_d[IDS_B_INSTR_CACHE] = cfg_q[IDS_B_INSTR_CACHE];
      status_d[IDS_B_UNITS]  = cfg_q[IDS_B_UNITS];
      status_d[IDS_B_CLKGEN] = cfg_q[IDS_B_CLKGEN] && cfg_q[IDS_B_CLKEN];
      status_d[IDS_B_EXTMEM] = cfg_q[IDS_B_EXTMEM];
      status_d[IDS_B_IOBUS]  = cfg_q[IDS_B_IOBUS];
      status_d[IDS_B_MBUS]   = cfg_q[IDS_B_MBUS];
      status_d[IDS_B_FETCH]  = cfg_q[IDS_B_FETCH];
      if (cfg_q[IDS_B_UNITS]) begin
        unit_d = select_q;
      end else begin
        unit_d = '0;
      end
    end
  end

  ids_sleep_cell #(.W(IDS_DOM_N)) u_domains (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .load_i  (load),
    .val_i   (status_d),
    .flag_q  (status_flags)
  );

  ids_sleep_cell #(.W(IDS_UNIT_N)) u_units (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .load_i  (load),
    .val_i   (unit_d),
    .flag_q  (unit_flags)
  );

  // Domain gates come straight from the status flops, so status and gates never disagree.
  always_comb begin
    core_sleep          = status_flags[IDS_B_CORE];
    master_domain_sleep = status_flags[IDS_B_MASTER];
    instr_cache_sleep   = status_flags[IDS_B_INSTR_CACHE];
    units_sleep         = status_flags[IDS_B_UNITS];
    clock_gen_sleep     = status_flags[IDS_B_CLKGEN];
    ext_memory_sleep    = status_flags[IDS_B_EXTMEM];
    io_space_bus_sleep  = status_flags[IDS_B_IOBUS];
    master_bus_sleep    = status_flags[IDS_B_MBUS];
    fetch_bus_sleep     = status_flags[IDS_B_FETCH];
    unit_sleep_vec      = unit_flags;
  end

  always_comb begin
    evt_set                = '0;
    evt_set[IDS_EV_ENTER]  = enter;
    evt_set[IDS_EV_WAKE]   = wake && any_asleep;
    evt_set[IDS_EV_BUSERR] = idle_exec && clk_seq_bad;
    evt_clr = '0;
    if (acc.wr && acc.idx == IDS_IDX_EVT_CLR && acc.be[0]) begin
      evt_clr = acc.wdata[IDS_EV_N-1:0];
    end
    // A new event outranks a clear landing in the same cycle.
    evt_stat_d = (evt_stat_q & ~evt_clr) | evt_set;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      evt_stat_q <= IDS_EV_RST;
    end else begin
      evt_stat_q <= evt_stat_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      evt_en_q <= IDS_EV_RST;
    end else if (acc.wr && acc.idx == IDS_IDX_EVT_EN && acc.be[0]) begin
      evt_en_q <= acc.wdata[IDS_EV_N-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_stat_d & evt_en_q);
    end
  end

  // A dedicated bus-error line, one cycle per refused idle, for the core's fault logic.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus_error_irq <= 1'b0;
    end else begin
      bus_error_irq <= idle_exec && clk_seq_bad;
    end
  end

  // The status register has no write path at all; unmapped indices read zero.
  always_comb begin
    rdata = '0;
    case (acc.idx)
      IDS_IDX_CFG:      rdata = cfg_q;
      IDS_IDX_STATUS:   rdata = {7'h00, status_flags};
      IDS_IDX_SELECT:   rdata = select_q & IDS_SELECT_MASK;
      IDS_IDX_EVT_STAT: rdata = {13'h0000, evt_stat_q};
      IDS_IDX_EVT_EN:   rdata = {13'h0000, evt_en_q};
      default:          rdata = '0;
    endcase
  end

endmodule : ids_idle_ctrl

// file: logic/ids_pkg.sv
/*
  Shared constants and carrier types of the idle domain control block: register
  indices, field positions, reset values, event bits and the slave handshake states.
  Assumes a 32-bit Avalon-MM bus with byte addresses; register index = address / 4.
*/
package ids_pkg;

  localparam int unsigned IDS_ADDR_W   = 10;
  localparam int unsigned IDS_DATA_W   = 32;
  localparam int unsigned IDS_REG_W    = 16;
  localparam int unsigned IDS_DOM_N    = 9;
  localparam int unsigned IDS_UNIT_N   = 16;
  localparam int unsigned IDS_EV_N     = 3;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDS_IDX_CFG      = 8'h01;
  localparam logic [7:0] IDS_IDX_STATUS   = 8'h02;
  localparam logic [7:0] IDS_IDX_SELECT   = 8'h03;
  localparam logic [7:0] IDS_IDX_EVT_STAT = 8'h04;
  localparam logic [7:0] IDS_IDX_EVT_EN   = 8'h05;
  localparam logic [7:0] IDS_IDX_EVT_CLR  = 8'h06;

  // Field positions; bits 0 to 8 are shared by the control and the status register, bit 9 is control only.
  localparam int unsigned IDS_B_CORE   = 0;
  localparam int unsigned IDS_B_MASTER = 1;
  localparam int unsigned IDS_B_INSTR_CACHE = 2;
  localparam int unsigned IDS_B_UNITS  = 3;
  localparam int unsigned IDS_B_CLKGEN = 4;
  localparam int unsigned IDS_B_EXTMEM = 5;
  localparam int unsigned IDS_B_IOBUS  = 6;
  localparam int unsigned IDS_B_MBUS   = 7;
  localparam int unsigned IDS_B_FETCH  = 8;
  localparam int unsigned IDS_B_CLKEN  = 9;

  // Domains that must already be set to sleep before the clock generator may stop.
  localparam logic [15:0] IDS_CLK_REQ_MASK = 16'h01E7;
  localparam logic [15:0] IDS_CFG_MASK     = 16'h03FF;
  localparam logic [15:0] IDS_SELECT_MASK  = 16'h3FFF;
  localparam logic [15:0] IDS_CFG_RST      = 16'h0000;
  localparam logic [15:0] IDS_SELECT_RST   = 16'h0000;
  localparam logic [8:0]  IDS_STATUS_RST   = 9'h000;
  localparam logic [2:0]  IDS_EV_RST       = 3'h0;

  // Event bits of the interrupt status, enable and clear registers.
  localparam int unsigned IDS_EV_ENTER  = 0;
  localparam int unsigned IDS_EV_WAKE   = 1;
  localparam int unsigned IDS_EV_BUSERR = 2;

  typedef enum logic [1:0] {
    IDS_HS_IDLE = 2'b01,
    IDS_HS_ACK  = 2'b10
  } ids_hs_state_t;

  typedef struct packed {
    logic                  read;
    logic                  write;
    logic [IDS_ADDR_W-1:0] addr;
    logic [IDS_DATA_W-1:0] wdata;
    logic [3:0]            be;
  } ids_av_req_t;

  typedef struct packed {
    logic                 wr;
    logic [7:0]           idx;
    logic [IDS_REG_W-1:0] wdata;
    logic [1:0]           be;
  } ids_reg_acc_t;

endpackage : ids_pkg

// file: logic/ids_sleep_cell.sv
/*
  A bank of sleep flags that load a new pattern on request and hold it otherwise.
  Assumes load and value come from logic on the same clock.
*/
`timescale 1ns/100ps
module ids_sleep_cell import ids_pkg::*; #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         load_i,
  input  wire logic [W-1:0] val_i,
  output logic      [W-1:0] flag_q
);

  // A flag moves only when its domain is really put to sleep or woken.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= '0;
    end else if (load_i) begin
      flag_q <= val_i;
    end
  end

endmodule : ids_sleep_cell

// file: verif/ids_idle_ctrl_props.sv
/*
  Checker for the idle domain control block: sleep flags, bus error and readback.
  Assumes a bind to ids_idle_ctrl; only its ports are seen.
*/
`timescale 1ns/100ps
module ids_idle_ctrl_props import ids_pkg::*; (
  input wire logic                  ref_clk,
  input wire logic                  rstn,
  input wire logic [IDS_DATA_W-1:0] avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic                  idle_exec,
  input wire logic                  wake_req,
  input wire logic                  core_sleep,
  input wire logic                  master_domain_sleep,
  input wire logic                  instr_cache_sleep,
  input wire logic                  units_sleep,
  input wire logic                  clock_gen_sleep,
  input wire logic                  ext_memory_sleep,
  input wire logic                  io_space_bus_sleep,
  input wire logic                  master_bus_sleep,
  input wire logic                  fetch_bus_sleep,
  input wire logic [IDS_UNIT_N-1:0] unit_sleep_vec,
  input wire logic                  bus_error_irq
);
  logic [8:0] flags;
  assign flags = {fetch_bus_sleep, master_bus_sleep, io_space_bus_sleep, ext_memory_sleep,
                  clock_gen_sleep, units_sleep, instr_cache_sleep, master_domain_sleep,
                  core_sleep};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_quiet; !idle_exec && !wake_req; endsequence
  sequence s_wake; wake_req && !idle_exec; endsequence
  sequence s_refused; idle_exec ##1 bus_error_irq; endsequence

  stable_flags_a: assert property (
    s_quiet |=> $stable(flags) && $stable(unit_sleep_vec)) else $error("flags moved unasked");
  wake_clears_a: assert property (
    s_wake |=> flags == 9'h000 && unit_sleep_vec == 16'h0000) else $error("wake left flags");
  berr_cause_a: assert property (
    bus_error_irq |-> $past(idle_exec)) else $error("bus error without idle");
  berr_hold_a: assert property (
    bus_error_irq |-> $stable(flags) && $stable(unit_sleep_vec)) else $error("refused idle acted");
  clk_needs_a: assert property (
    clock_gen_sleep |-> (flags & 9'h1E7) == 9'h1E7) else $error("clock stopped too early");
  units_vec_a: assert property (
    !units_sleep |-> unit_sleep_vec == 16'h0000) else $error("unit asleep without flag");
  sel_top_a: assert property (
    unit_sleep_vec[15:14] == 2'h0) else $error("reserved unit asleep");
  rdata_upper_a: assert property (
    !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000) else $error("upper read bits set");
  refused_c: cover property (s_refused);
endmodule : ids_idle_ctrl_props

// file: verif/tb.sv
/*
  Self-checking bench of the idle domain control block over Avalon-MM.
  Assumes the one-wait-cycle slave and one-cycle idle answer of the block.
*/
`timescale 1ns/100ps
module tb import ids_pkg::*;;
  logic                  ref_clk, rstn, avs_read, avs_write, idle_exec, wake_req;
  logic [IDS_ADDR_W-1:0] avs_address;
  logic [IDS_DATA_W-1:0] avs_writedata, avs_readdata;
  logic [3:0]            avs_byteenable;
  logic                  avs_waitrequest, bus_error_irq, irq;
  logic                  core_s, mdom_s, instr_cache_s, units_s, clk_s, ext_s, io_s, mbus_s, fetch_s;
  logic [IDS_UNIT_N-1:0] unit_sleep_vec;
  logic [8:0]            flags;
  int                    n_mismatch, n_compared;
  assign flags = {fetch_s, mbus_s, io_s, ext_s, clk_s, units_s, instr_cache_s, mdom_s, core_s};

  ids_idle_ctrl DUT (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .idle_exec(idle_exec), .wake_req(wake_req),
    .core_sleep(core_s), .master_domain_sleep(mdom_s), .instr_cache_sleep(instr_cache_s),
    .units_sleep(units_s), .clock_gen_sleep(clk_s), .ext_memory_sleep(ext_s),
    .io_space_bus_sleep(io_s), .master_bus_sleep(mbus_s), .fetch_bus_sleep(fetch_s),
    .unit_sleep_vec(unit_sleep_vec), .bus_error_irq(bus_error_irq), .irq(irq));

  always #5 ref_clk = ~ref_clk;

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task results;
    $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // The request is held until waitrequest is sampled low; the bound catches a hang.
  task bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
           output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {16'h0000, wd};
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      n_mismatch++;
      results();
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask : wr

  task rdc(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 16'h0000, x);
    chk(what, exp, x);
  endtask : rdc

  task pulse(input logic wake);
    @(posedge ref_clk);
    if (wake) wake_req <= 1'b1;
    else idle_exec <= 1'b1;
    @(posedge ref_clk);
    wake_req  <= 1'b0;
    idle_exec <= 1'b0;
    #1;
  endtask : pulse

  task t_regs;
    rdc("status reset", IDS_IDX_STATUS, 32'h0);
    rdc("select reset", IDS_IDX_SELECT, 32'h0);
    wr(IDS_IDX_STATUS, 16'h01FF);
    rdc("status written", IDS_IDX_STATUS, 32'h0);
    // Only the low byte lane is enabled, so the upper select bits must stay clear.
    avs_byteenable <= 4'h1;
    wr(IDS_IDX_SELECT, 16'hFFFF);
    avs_byteenable <= 4'hF;
    rdc("select low byte", IDS_IDX_SELECT, 32'h00FF);
    wr(IDS_IDX_SELECT, 16'hFFFF);
    rdc("select top", IDS_IDX_SELECT, 32'h3FFF);
    rdc("unmapped", 8'h3F, 32'h0);
  endtask : t_regs

  task t_domains;
    for (int i = 0; i < 9; i++) begin
      if (i != 3 && i != 4) begin
        wr(IDS_IDX_CFG, 16'h0001 << i);
        pulse(1'b0);
        chk("domain flags", 32'h1 << i, {23'h0, flags});
        rdc("status", IDS_IDX_STATUS, 32'h1 << i);
        pulse(1'b1);
        chk("woken", 32'h0, {23'h0, flags});
      end
    end
  endtask : t_domains

  task t_units;
    wr(IDS_IDX_SELECT, 16'h0005);
    wr(IDS_IDX_CFG, 16'h0008);
    pulse(1'b0);
    chk("units vec", 32'h5, {16'h0, unit_sleep_vec});
    chk("units flag", 32'h8, {23'h0, flags});
    wr(IDS_IDX_SELECT, 16'h0004);
    pulse(1'b0);
    chk("units rewake", 32'h4, {16'h0, unit_sleep_vec});
    wr(IDS_IDX_CFG, 16'h0000);
    pulse(1'b0);
    chk("units awake", 32'h0, {16'h0, unit_sleep_vec});
    chk("units flag off", 32'h0, {23'h0, flags});
  endtask : t_units

  task t_clock;
    // Earlier idles and wakes have left their events pending; clear them first.
    rdc("event history", IDS_IDX_EVT_STAT, 32'h3);
    wr(IDS_IDX_EVT_CLR, 16'h0003);
    rdc("event cleared", IDS_IDX_EVT_STAT, 32'h0);
    wr(IDS_IDX_EVT_EN, 16'h0004);
    wr(IDS_IDX_CFG, 16'h0210);
    pulse(1'b0);
    chk("bus error", 32'h1, {31'h0, bus_error_irq});
    chk("refused flags", 32'h0, {23'h0, flags});
    @(posedge ref_clk);
    #1;
    chk("irq raised", 32'h1, {31'h0, irq});
    rdc("event status", IDS_IDX_EVT_STAT, 32'h4);
    wr(IDS_IDX_EVT_CLR, 16'h0004);
    @(posedge ref_clk);
    #1;
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(IDS_IDX_EVT_EN, 16'h0000);
    pulse(1'b0);
    @(posedge ref_clk);
    #1;
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(IDS_IDX_EVT_CLR, 16'h0004);
    wr(IDS_IDX_CFG, 16'h03FF);
    pulse(1'b0);
    chk("all asleep", 32'h1FF, {23'h0, flags});
    chk("no bus error", 32'h0, {31'h0, bus_error_irq});
    pulse(1'b1);
  endtask : t_clock

  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 10'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    idle_exec = 1'b0;
    wake_req = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs();
    t_domains();
    t_units();
    t_clock();
    results();
  end
endmodule : tb

bind ids_idle_ctrl ids_idle_ctrl_props u_props (.ref_clk(ref_clk), .rstn(rstn),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .idle_exec(idle_exec),
  .wake_req(wake_req), .core_sleep(core_sleep), .master_domain_sleep(master_domain_sleep),
  .instr_cache_sleep(instr_cache_sleep), .units_sleep(units_sleep),
  .clock_gen_sleep(clock_gen_sleep), .ext_memory_sleep(ext_memory_sleep),
  .io_space_bus_sleep(io_space_bus_sleep), .master_bus_sleep(master_bus_sleep),
  .fetch_bus_sleep(fetch_bus_sleep), .unit_sleep_vec(unit_sleep_vec),
  .bus_error_irq(bus_error_irq));
